// ==== hw/lms_exec.sv ====
// Execution unit for mask load, flag load, context block load and scans.
// Assumes a decoder supplies operands and effective addresses, and a
// storage port on the same clock answers each request with one ack.
//
// Functional notes
// RULE1: mask takes storage word bits 0-3
// RULE2: mask bit n enables level n
// RULE3: mask and block loads need supervisor
// RULE4: odd mask address gives specification check
// RULE5: flag load copies register bits 0-4
// RULE6: indicator bits even carry overflow negative zero
// RULE7: block load reads eleven words unchanged
// RULE8: target level from register bits 14-15
// RULE9: inhibit holds trace past next instruction
// RULE10: no inhibit allows trace at completion
// RULE11: block used if in-process and level allowed
// RULE12: block is pointer, zero, status, registers
// RULE13: other level leaves current state untouched
// RULE14: address mode 01 adds two to base
// RULE15: bad or odd block address terminates
// RULE16: scan compares low byte, counts in seven
// RULE17: scan compare writes back neither operand
// RULE18: bit 13 picks address step direction
// RULE19: match scan stops, match not counted
// RULE20: scans interruptible, zero count is no-op
// RULE21: scan sets byte carry and overflow
// RULE22: bad scan operand address terminates
// RULE23: mismatch scan stops on differing byte
module lms_exec (
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_start,
  input  wire lms_pkg::lms_op_t i_op,
  input  wire logic             i_supervisor,
  input  wire logic             i_scan_up,
  input  wire logic [15:0]      i_ea,
  input  wire logic             i_ea_invalid,
  input  wire logic             i_indirect_odd,
  input  wire logic [1:0]       i_addr_mode,
  input  wire logic [2:0]       i_base_reg_sel,
  input  wire logic [15:0]      i_base_reg_val,
  input  wire logic [15:0]      i_first_reg_val,
  input  wire logic [2:0]       i_second_reg_sel,
  input  wire logic [15:0]      i_second_reg_val,
  input  wire logic [15:0]      i_count_val,
  input  wire logic [1:0]       i_cur_level,
  input  wire logic             i_irq_pending,
  input  wire logic             i_instr_retired,
  input  wire logic             i_mem_ack,
  input  wire logic             i_mem_err,
  input  wire logic [15:0]      i_mem_rdata,
  output logic                  o_mem_req,
  output logic      [15:0]      o_mem_addr,
  output logic                  o_mem_byte,
  output logic      [3:0]       o_level_enable_mask,
  output logic      [15:0]      o_level_status_word,
  output logic                  o_wb_valid,
  output logic      [1:0]       o_wb_level,
  output logic      [3:0]       o_wb_idx,
  output logic      [15:0]      o_wb_data,
  output logic                  o_level_switch,
  output logic      [1:0]       o_target_level,
  output logic                  o_trace_enable,
  output logic                  o_trace_hold,
  output logic                  o_done,
  output logic                  o_prog_check,
  output lms_pkg::lms_chk_t     o_check_code
);
  import lms_pkg::*;

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE     = 3'h0,
    S_MASK_RD  = 3'h1,
    S_BLK_LSW  = 3'h2,
    S_BLK_RD   = 3'h3,
    S_BLK_END  = 3'h4,
    S_SCAN_RD  = 3'h5,
    S_SCAN_WB  = 3'h6,
    S_SCAN_CNT = 3'h7
  } lms_state_t;

  function automatic logic [15:0] blk_addr(input logic [15:0] base, input logic [3:0] idx);
    blk_addr = base + {11'h000, idx, 1'b0};
  endfunction : blk_addr

  lms_state_t  state, next_state;
  lms_op_t     op_q, next_op_q;
  logic [15:0] ea_q, next_ea_q, addr_q, next_addr_q, cnt_q, next_cnt_q;
  logic [15:0] rb_val_q, next_rb_val_q;
  logic [7:0]  rbyte_q, next_rbyte_q;
  logic [3:0]  blk_idx_q, next_blk_idx_q;
  logic [2:0]  rb_sel_q, next_rb_sel_q, sel2_q, next_sel2_q;
  logic [1:0]  req_lvl_q, next_req_lvl_q, cur_q, next_cur_q, am_q, next_am_q;
  logic        up_q, next_up_q, it_q, next_it_q, tgt_trace_q, next_tgt_trace_q;
  logic        used_q, next_used_q;
  logic        next_mem_req, next_mem_byte, next_wb_valid, next_level_switch;
  logic        next_trace_enable, next_trace_hold, next_done, next_prog_check;
  logic [15:0] next_mem_addr, next_lsw, next_wb_data;
  logic [3:0]  next_mask, next_wb_idx;
  logic [1:0]  next_wb_level, next_target_level;
  lms_chk_t    next_check_code, chk;
  logic        fin, hit;
  logic [15:0] cnt_dec;
  logic [7:0]  cmp_diff;
  logic        cmp_borrow, cmp_ovf, cmp_even, cmp_neg, cmp_zero;

  lms_byte_cmp u_cmp ( // RULE17
    .i_stor_byte (i_mem_rdata[7:0]),
    .i_reg_byte  (rbyte_q),
    .o_diff      (cmp_diff),
    .o_borrow    (cmp_borrow),
    .o_ovf       (cmp_ovf),
    .o_even      (cmp_even),
    .o_neg       (cmp_neg),
    .o_zero      (cmp_zero)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;           next_op_q = op_q;
    next_ea_q = ea_q;             next_addr_q = addr_q;
    next_cnt_q = cnt_q;           next_rb_val_q = rb_val_q;
    next_rbyte_q = rbyte_q;       next_blk_idx_q = blk_idx_q;
    next_rb_sel_q = rb_sel_q;     next_sel2_q = sel2_q;
    next_req_lvl_q = req_lvl_q;   next_cur_q = cur_q;
    next_am_q = am_q;             next_up_q = up_q;
    next_it_q = it_q;             next_tgt_trace_q = tgt_trace_q;
    next_used_q = used_q;         next_mem_req = o_mem_req;
    next_mem_addr = o_mem_addr;   next_mem_byte = o_mem_byte;
    next_mask = o_level_enable_mask;
    next_lsw = o_level_status_word;
    next_wb_valid = 1'b0;         next_wb_level = o_wb_level;
    next_wb_idx = o_wb_idx;       next_wb_data = o_wb_data;
    next_level_switch = 1'b0;     next_target_level = o_target_level;
    next_trace_enable = o_trace_enable;
    next_trace_hold = o_trace_hold;
    next_done = 1'b0;             next_prog_check = 1'b0;
    next_check_code = CHK_NONE;
    chk = CHK_NONE;
    fin = 1'b0;
    hit = 1'b0;
    cnt_dec = cnt_q - BYTE_STEP;
    if (i_instr_retired) begin
      next_trace_hold = 1'b0; // RULE9
    end
    unique case (state)
      S_IDLE: begin
        if (i_start) begin
          next_op_q = i_op;
          next_ea_q = i_ea;
          next_up_q = i_scan_up;
          next_rbyte_q = i_first_reg_val[7:0]; // RULE16
          next_addr_q = i_second_reg_val;
          next_cnt_q = i_count_val;
          next_sel2_q = i_second_reg_sel;
          next_req_lvl_q = i_first_reg_val[1:0]; // RULE8
          next_it_q = i_first_reg_val[LVL_INHIBIT];
          next_cur_q = i_cur_level;
          next_am_q = i_addr_mode;
          next_rb_sel_q = i_base_reg_sel;
          next_rb_val_q = i_base_reg_val;
          if ((i_op == OP_LOAD_LEVEL_MASK || i_op == OP_LOAD_CONTEXT_BLOCK)
              && !i_supervisor) begin
            chk = CHK_PRIV; // RULE3
            fin = 1'b1;
          end else begin
            unique case (i_op)
              OP_LOAD_LEVEL_MASK, OP_LOAD_CONTEXT_BLOCK: begin
                if (i_ea_invalid) begin
                  chk = CHK_INVALID; // RULE15
                  fin = 1'b1;
                end else if (i_indirect_odd || i_ea[0]) begin
                  chk = CHK_SPEC; // RULE4 RULE15
                  fin = 1'b1;
                end else if (i_op == OP_LOAD_LEVEL_MASK) begin
                  next_mem_req = 1'b1;
                  next_mem_addr = i_ea;
                  next_mem_byte = 1'b0;
                  next_state = S_MASK_RD;
                end else begin
                  next_mem_req = 1'b1;
                  next_mem_addr = blk_addr(i_ea, BLK_IDX_LSW);
                  next_mem_byte = 1'b0;
                  next_state = S_BLK_LSW;
                end
              end
              OP_LOAD_FLAGS: begin
                next_lsw[LSW_EVEN:LSW_ZERO] = i_second_reg_val[15:11]; // RULE5 RULE6
                fin = 1'b1;
              end
              OP_SCAN_MATCH, OP_SCAN_MISMATCH: begin
                if (i_count_val == COUNT_ZERO) begin
                  fin = 1'b1; // RULE20
                end else begin
                  next_mem_req = 1'b1;
                  next_mem_addr = i_second_reg_val;
                  next_mem_byte = 1'b1;
                  next_state = S_SCAN_RD;
                end
              end
              default: begin
                fin = 1'b1;
              end
            endcase
          end
        end
      end
      S_MASK_RD: begin
        if (i_mem_ack) begin
          next_mem_req = 1'b0;
          if (i_mem_err) begin
            chk = CHK_INVALID;
          end else begin
            for (int n = 0; n < NUM_LEVELS; n++) begin
              next_mask[n] = i_mem_rdata[MASK_TOP - n]; // RULE1 RULE2
            end
          end
          fin = 1'b1;
        end
      end
      S_BLK_LSW: begin
        if (i_mem_ack) begin
          next_mem_req = 1'b0;
          if (i_mem_err) begin
            chk = CHK_INVALID; // RULE15
            fin = 1'b1;
          end else if (i_mem_rdata[LSW_IN_PROCESS] && req_lvl_q <= cur_q) begin
            next_used_q = 1'b1; // RULE11
            next_tgt_trace_q = i_mem_rdata[LSW_TRACE];
            next_blk_idx_q = BLK_IDX_IAR;
            next_mem_req = 1'b1;
            next_mem_addr = blk_addr(ea_q, BLK_IDX_IAR);
            next_state = S_BLK_RD;
          end else begin
            next_used_q = 1'b0; // RULE11
            next_tgt_trace_q = o_level_status_word[LSW_TRACE];
            next_state = S_BLK_END;
          end
        end
      end
      S_BLK_RD: begin
        if (i_mem_ack) begin
          next_mem_req = 1'b0;
          if (i_mem_err) begin
            chk = CHK_INVALID; // RULE15
            fin = 1'b1;
          end else begin
            next_wb_level = req_lvl_q;
            next_wb_data = i_mem_rdata;
            if (blk_idx_q == BLK_IDX_IAR) begin
              next_wb_valid = 1'b1; // RULE12
              next_wb_idx = WB_IAR;
            end else if (blk_idx_q == BLK_IDX_LSW) begin
              if (req_lvl_q == cur_q) begin
                next_lsw = i_mem_rdata;
              end else begin
                next_wb_valid = 1'b1; // RULE13
                next_wb_idx = WB_LSW;
              end
            end else if (blk_idx_q >= BLK_IDX_REG0) begin
              next_wb_valid = 1'b1; // RULE12
              next_wb_idx = blk_idx_q - BLK_IDX_REG0;
            end
            if (blk_idx_q == BLK_LAST_IDX) begin
              next_state = S_BLK_END; // RULE7
            end else begin
              next_blk_idx_q = blk_idx_q + 4'h1;
              next_mem_req = 1'b1;
              next_mem_addr = blk_addr(ea_q, blk_idx_q + 4'h1);
            end
          end
        end
      end
      S_BLK_END: begin
        if (am_q == AM_BASE_INC) begin
          next_wb_valid = 1'b1; // RULE14
          next_wb_level = cur_q;
          next_wb_idx = {1'b0, rb_sel_q};
          next_wb_data = rb_val_q + BASE_INC;
        end
        next_trace_enable = tgt_trace_q; // RULE10
        next_trace_hold = it_q & tgt_trace_q; // RULE9
        next_target_level = used_q ? req_lvl_q : cur_q;
        next_level_switch = used_q && (req_lvl_q != cur_q);
        fin = 1'b1;
      end
      S_SCAN_RD: begin
        if (i_mem_ack) begin
          next_mem_req = 1'b0;
          if (i_mem_err) begin
            chk = CHK_INVALID; // RULE22
            fin = 1'b1;
          end else begin
            next_lsw[LSW_CARRY] = cmp_borrow; // RULE21
            next_lsw[LSW_OVF] = cmp_ovf; // RULE21
            next_lsw[LSW_EVEN] = cmp_even;
            next_lsw[LSW_NEG] = cmp_neg;
            next_lsw[LSW_ZERO] = cmp_zero;
            next_addr_q = up_q ? addr_q + BYTE_STEP : addr_q - BYTE_STEP; // RULE18
            hit = (op_q == OP_SCAN_MATCH) ? cmp_zero : !cmp_zero; // RULE19 RULE23
            if (hit) begin
              next_state = S_SCAN_WB; // RULE19
            end else begin
              next_cnt_q = cnt_dec; // RULE16
              if (cnt_dec == COUNT_ZERO || i_irq_pending) begin
                next_state = S_SCAN_WB; // RULE20
              end else begin
                next_mem_req = 1'b1;
                next_mem_addr = next_addr_q;
              end
            end
          end
        end
      end
      S_SCAN_WB: begin
        next_wb_valid = 1'b1;
        next_wb_level = cur_q;
        next_wb_idx = {1'b0, sel2_q};
        next_wb_data = addr_q;
        next_state = S_SCAN_CNT;
      end
      S_SCAN_CNT: begin
        next_wb_valid = 1'b1;
        next_wb_level = cur_q;
        next_wb_idx = {1'b0, COUNT_REG};
        next_wb_data = cnt_q;
        fin = 1'b1;
      end
    endcase
    if (fin) begin
      next_done = 1'b1;
      next_prog_check = (chk != CHK_NONE);
      next_check_code = chk;
      next_state = S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state <= S_IDLE;             op_q <= OP_LOAD_LEVEL_MASK;
      ea_q <= 16'h0000;            addr_q <= 16'h0000;
      cnt_q <= 16'h0000;           rb_val_q <= 16'h0000;
      rbyte_q <= 8'h00;            blk_idx_q <= 4'h0;
      rb_sel_q <= 3'h0;            sel2_q <= 3'h0;
      req_lvl_q <= 2'h0;           cur_q <= 2'h0;
      am_q <= 2'h0;                up_q <= 1'b0;
      it_q <= 1'b0;                tgt_trace_q <= 1'b0;
      used_q <= 1'b0;              o_mem_req <= 1'b0;
      o_mem_addr <= 16'h0000;      o_mem_byte <= 1'b0;
      o_level_enable_mask <= MASK_RESET;
      o_level_status_word <= LSW_RESET;
      o_wb_valid <= 1'b0;          o_wb_level <= 2'h0;
      o_wb_idx <= 4'h0;            o_wb_data <= 16'h0000;
      o_level_switch <= 1'b0;      o_target_level <= 2'h0;
      o_trace_enable <= 1'b0;      o_trace_hold <= 1'b0;
      o_done <= 1'b0;              o_prog_check <= 1'b0;
      o_check_code <= CHK_NONE;
    end else begin
      state <= next_state;         op_q <= next_op_q;
      ea_q <= next_ea_q;           addr_q <= next_addr_q;
      cnt_q <= next_cnt_q;         rb_val_q <= next_rb_val_q;
      rbyte_q <= next_rbyte_q;     blk_idx_q <= next_blk_idx_q;
      rb_sel_q <= next_rb_sel_q;   sel2_q <= next_sel2_q;
      req_lvl_q <= next_req_lvl_q; cur_q <= next_cur_q;
      am_q <= next_am_q;           up_q <= next_up_q;
      it_q <= next_it_q;           tgt_trace_q <= next_tgt_trace_q;
      used_q <= next_used_q;       o_mem_req <= next_mem_req;
      o_mem_addr <= next_mem_addr; o_mem_byte <= next_mem_byte;
      o_level_enable_mask <= next_mask;
      o_level_status_word <= next_lsw;
      o_wb_valid <= next_wb_valid; o_wb_level <= next_wb_level;
      o_wb_idx <= next_wb_idx;     o_wb_data <= next_wb_data;
      o_level_switch <= next_level_switch;
      o_target_level <= next_target_level;
      o_trace_enable <= next_trace_enable;
      o_trace_hold <= next_trace_hold;
      o_done <= next_done;         o_prog_check <= next_prog_check;
      o_check_code <= next_check_code;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  logic scan_ok;
  assign scan_ok = (state == S_SCAN_RD) && i_mem_ack && !i_mem_err;

  AST_MASK_LOAD: assert property ( // RULE1
    (state == S_MASK_RD && i_mem_ack && !i_mem_err) |=> o_done && !o_prog_check
      && o_level_enable_mask[3:1] == {$past(i_mem_rdata[12]), $past(i_mem_rdata[13]),
      $past(i_mem_rdata[14])})
    else $error("mask not loaded from storage bits 0-3");
  AST_MASK_LEVEL0: assert property ( // RULE2
    (state == S_MASK_RD && i_mem_ack && !i_mem_err)
      |=> o_level_enable_mask[0] == $past(i_mem_rdata[15]))
    else $error("level 0 enable not from storage bit 0");
  AST_PRIV: assert property ( // RULE3
    (state == S_IDLE && i_start && !i_supervisor
      && (i_op == OP_LOAD_LEVEL_MASK || i_op == OP_LOAD_CONTEXT_BLOCK))
      |=> o_done && o_prog_check && o_check_code == CHK_PRIV && !o_mem_req)
    else $error("privileged op ran outside supervisor state");
  AST_MASK_SPEC: assert property ( // RULE4
    (state == S_IDLE && i_start && i_supervisor && i_op == OP_LOAD_LEVEL_MASK
      && !i_ea_invalid && i_ea[0])
      |=> o_check_code == CHK_SPEC && $stable(o_level_status_word)
      && $stable(o_level_enable_mask))
    else $error("odd mask address not checked");
  AST_FLAGS: assert property ( // RULE5
    (state == S_IDLE && i_start && i_op == OP_LOAD_FLAGS)
      |=> o_level_status_word[LSW_EVEN:LSW_ZERO] == $past(i_second_reg_val[15:11])
      && o_level_status_word[10:0] == $past(o_level_status_word[10:0]))
    else $error("flag load wrong");
  AST_SCAN_NOOP: assert property ( // RULE20
    (state == S_IDLE && i_start && i_op == OP_SCAN_MATCH && i_count_val == COUNT_ZERO)
      |=> o_done && !o_mem_req && !o_wb_valid)
    else $error("zero count scan not a no-op");
  AST_SCAN_DIR: assert property ( // RULE18
    scan_ok |=> addr_q == ($past(up_q) ? $past(addr_q) + BYTE_STEP
      : $past(addr_q) - BYTE_STEP))
    else $error("scan address stepped wrong way");
  AST_SCAN_CARRY: assert property ( // RULE21
    scan_ok |=> o_level_status_word[LSW_CARRY] == $past(cmp_borrow)
      && o_level_status_word[LSW_OVF] == $past(cmp_ovf))
    else $error("scan carry or overflow wrong");
  AST_MATCH_STOP: assert property ( // RULE19
    (scan_ok && op_q == OP_SCAN_MATCH && cmp_zero)
      |=> state == S_SCAN_WB && $stable(cnt_q) ##2 o_done)
    else $error("match scan did not stop uncounted");
  AST_TRACE_HOLD: assert property ( // RULE9
    (state == S_BLK_END && !i_instr_retired) |=> o_trace_hold == $past(it_q & tgt_trace_q))
    else $error("trace hold wrong after block load");
  AST_BASE_INC: assert property ( // RULE14
    (state == S_BLK_END && am_q == AM_BASE_INC)
      |=> o_wb_valid && o_wb_data == $past(rb_val_q) + BASE_INC)
    else $error("base register not advanced by two");

  COV_MASK: cover property (state == S_MASK_RD && i_mem_ack ##1 o_done);
  COV_BLOCK: cover property (state == S_BLK_RD && blk_idx_q == BLK_LAST_IDX && i_mem_ack);
  COV_SCAN_IRQ: cover property (scan_ok && i_irq_pending && cnt_dec != COUNT_ZERO);

endmodule : lms_exec

// ==== hw/lms_pkg.sv ====
// Shared constants and types for the level, mask and scan execution unit.
// Assumes documented bit n of a 16-bit word sits at index 15-n.
package lms_pkg;

  // ----------------------------------------------------------------
  // Operations and check codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_LOAD_LEVEL_MASK    = 3'h0,
    OP_LOAD_FLAGS         = 3'h1,
    OP_LOAD_CONTEXT_BLOCK = 3'h2,
    OP_SCAN_MATCH         = 3'h3,
    OP_SCAN_MISMATCH      = 3'h4
  } lms_op_t;

  typedef enum logic [1:0] {
    CHK_NONE    = 2'h0,
    CHK_PRIV    = 2'h1,
    CHK_SPEC    = 2'h2,
    CHK_INVALID = 2'h3
  } lms_chk_t;

  // ----------------------------------------------------------------
  // Level status word fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned LSW_EVEN       = 15;
  localparam int unsigned LSW_CARRY      = 14;
  localparam int unsigned LSW_OVF        = 13;
  localparam int unsigned LSW_NEG        = 12;
  localparam int unsigned LSW_ZERO       = 11;
  localparam int unsigned LSW_IN_PROCESS = 7;
  localparam int unsigned LSW_TRACE      = 5;
  localparam logic [15:0] LSW_RESET      = 16'h0000;
  localparam logic [3:0]  MASK_RESET     = 4'h0;
  localparam int unsigned MASK_TOP       = 15;
  localparam int unsigned NUM_LEVELS     = 4;
  localparam int unsigned LVL_INHIBIT    = 15;

  // ----------------------------------------------------------------
  // Status block layout and register numbers
  // ----------------------------------------------------------------
  localparam logic [3:0]  BLK_LAST_IDX = 4'ha;
  localparam logic [3:0]  BLK_IDX_IAR  = 4'h0;
  localparam logic [3:0]  BLK_IDX_LSW  = 4'h2;
  localparam logic [3:0]  BLK_IDX_REG0 = 4'h3;
  localparam logic [15:0] BLK_LAST_OFS = 16'h0014;
  localparam logic [3:0]  WB_IAR       = 4'h8;
  localparam logic [3:0]  WB_LSW       = 4'h9;
  localparam logic [2:0]  COUNT_REG    = 3'h7;
  localparam logic [1:0]  AM_BASE_INC  = 2'h1;
  localparam logic [15:0] BASE_INC     = 16'h0002;
  localparam logic [15:0] BYTE_STEP    = 16'h0001;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;

endpackage : lms_pkg

// ==== hw/lms_byte_cmp.sv ====
// Byte subtraction for the scan unit: storage byte minus register byte.
// Purely combinational; the caller registers the results.
module lms_byte_cmp (
  input  wire logic [7:0] i_stor_byte,
  input  wire logic [7:0] i_reg_byte,
  output logic      [7:0] o_diff,
  output logic            o_borrow,
  output logic            o_ovf,
  output logic            o_even,
  output logic            o_neg,
  output logic            o_zero
);

  logic [8:0] wide;

  always_comb begin
    wide     = {1'b0, i_stor_byte} - {1'b0, i_reg_byte};
    o_diff   = wide[7:0];
    o_borrow = wide[8];
    // Signed overflow: operands differ in sign and the result sign flips.
    o_ovf    = (i_stor_byte[7] ^ i_reg_byte[7]) & (wide[7] ^ i_stor_byte[7]);
    o_even   = ~wide[0];
    o_neg    = wide[7];
    o_zero   = (wide[7:0] == 8'h00);
  end

endmodule : lms_byte_cmp

// ==== verif/lms_mem.sv ====
// Byte storage model that answers the unit's read requests, sometimes a cycle late.
// Assumes each request is held until the cycle after its acknowledge.
module lms_mem (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_byte,
  output logic             o_ack,
  output logic             o_err,
  output logic      [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:255];
  logic [7:0]  a;
  logic [1:0]  tick = 2'h0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  // Storage has no write path, so no operation can alter it.
  always @(posedge i_ref_clk) begin
    a = i_addr[7:0];
    tick <= tick + 2'h1;
    o_ack <= !i_sys_rst && i_req && !o_ack && tick != 2'h3;
    o_err <= i_addr[15];
    o_rdata <= (i_req && !o_ack) ? (i_byte ? {8'h00, mem[a]} : {mem[a], mem[a + 8'h01]})
                                 : ~o_rdata;
  end
endmodule : lms_mem

// ==== verif/level_mask_scan_execution_bench.sv ====
// Bench for the execution unit: operation calls with expected results.
// Assumes storage is modelled by lms_mem, with bit 15 of an address marking it invalid.
module level_mask_scan_execution_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lms_pkg::*;
  logic clk = 0, rst = 1, start = 0, sup = 0, up = 0, ack, err, req, mb, done, pc, wbv;
  logic [1:0] am = 2'h1;
  logic [2:0] bsel = 3'h1, ssel = 3'h2;
  lms_op_t op = OP_LOAD_FLAGS;
  lms_chk_t code, got;
  logic [15:0] ea = 0, r1 = 0, r2 = 0, cnt = 0, base = 16'h0040, rd, ma, lsw, wbd;
  logic [17:0] wbq [0:15];
  logic [3:0] mask, wbi;
  logic [1:0] flt = 2'h0, cl = 2'h0, tl, wl;
  logic irq = 0, ret = 0, sw, pchk, ls, te, th;
  int miscompares = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  lms_exec dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_start(start), .i_op(op),
    .i_supervisor(sup), .i_scan_up(up), .i_ea(ea), .i_ea_invalid(flt[1]),
    .i_indirect_odd(flt[0]), .i_addr_mode(am), .i_base_reg_sel(bsel), .i_base_reg_val(base),
    .i_first_reg_val(r1), .i_second_reg_sel(ssel), .i_second_reg_val(r2),
    .i_count_val(cnt), .i_cur_level(cl), .i_irq_pending(irq), .i_instr_retired(ret),
    .i_mem_ack(ack), .i_mem_err(err), .i_mem_rdata(rd), .o_mem_req(req), .o_mem_addr(ma),
    .o_mem_byte(mb), .o_level_enable_mask(mask), .o_level_status_word(lsw),
    .o_wb_valid(wbv), .o_wb_level(wl), .o_wb_idx(wbi), .o_wb_data(wbd),
    .o_level_switch(ls), .o_target_level(tl), .o_trace_enable(te), .o_trace_hold(th),
    .o_done(done), .o_prog_check(pc), .o_check_code(code));
  lms_mem stor (.i_ref_clk(clk), .i_sys_rst(rst), .i_req(req), .i_addr(ma), .i_byte(mb),
    .o_ack(ack), .o_err(err), .o_rdata(rd));
  always @(posedge clk) if (wbv) wbq[wbi] <= {wl, wbd};
  task automatic ck(input logic bad, input string m);
    samples_checked++;
    if (bad) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : ck
  task automatic run(input lms_op_t o, input logic s, input logic [15:0] a, v1, v2, c,
                     input logic u);
    @(negedge clk);
    {op, sup, ea, r1, r2, cnt, up, start} = {o, s, a, v1, v2, c, u, 1'b1};
    @(negedge clk);
    start = 0;
    for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
    ck(done !== 1'b1, "no completion");
    got = code;
    {sw, pchk} = {ls, pc};
    @(negedge clk);
  endtask : run
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    {stor.mem[0], stor.mem[16], stor.mem[17], stor.mem[18]} = 32'ha5112233;
    {stor.mem[30], stor.mem[31], stor.mem[32]} = 24'h052222;
    {stor.mem[101], stor.mem[117]} = 16'ha077;
    run(OP_LOAD_LEVEL_MASK, 1, 16'h0000, 0, 0, 0, 0);
    ck(got !== CHK_NONE || mask !== 4'h5, "mask load");
    for (int k = 0; k < 2; k++) begin
      run(k ? OP_LOAD_CONTEXT_BLOCK : OP_LOAD_LEVEL_MASK, 0, 16'h0040, 0, 0, 0, 0);
      ck(got !== CHK_PRIV || pchk !== 1'b1 || mask !== 4'h5, "privilege");
    end
    run(OP_LOAD_LEVEL_MASK, 1, 16'h0001, 0, 0, 0, 0);
    ck(got !== CHK_SPEC || mask !== 4'h5, "odd mask address");
    run(OP_LOAD_FLAGS, 0, 0, 0, 16'hffff, 0, 0);
    ck(lsw !== 16'hf800 || pchk !== 1'b0, "flag load");
    run(OP_SCAN_MATCH, 0, 0, 16'hff22, 16'h0010, 16'h0003, 1);
    ck(lsw !== 16'h8800 || wbq[7] !== 16'h0002 || wbq[2] !== 16'h0012, "match");
    run(OP_SCAN_MISMATCH, 0, 0, 16'h0022, 16'h0020, 16'h0003, 0);
    ck(lsw !== 16'h5000 || wbq[7] !== 16'h0001 || wbq[2] !== 16'h001d, "mis");
    run(OP_SCAN_MATCH, 0, 0, 16'h0022, 16'h0010, 16'h0000, 1);
    ck(got !== CHK_NONE || lsw !== 16'h5000, "zero count");
    run(OP_SCAN_MATCH, 0, 0, 16'h0022, 16'h8000, 16'h0002, 1);
    ck(got !== CHK_INVALID, "bad scan address");
    run(OP_LOAD_CONTEXT_BLOCK, 1, 16'h0040, 0, 0, 0, 0);
    ck(got !== CHK_NONE || lsw !== 16'h5000 || wbq[1] !== 16'h0042, "block");
    run(OP_LOAD_CONTEXT_BLOCK, 1, 16'h0041, 0, 0, 0, 0);
    ck(got !== CHK_SPEC, "odd block address");
    irq = 1;
    run(OP_SCAN_MATCH, 0, 0, 16'h0080, 16'h0010, 16'h0003, 1);
    irq = 0;
    ck(lsw !== 16'h7000 || wbq[7] !== 16'h2 || wbq[2] !== 16'h11, "irq scan");
    for (int k = 1; k < 3; k++) begin
      flt = k[1:0];
      run(k[1] ? OP_LOAD_CONTEXT_BLOCK : OP_LOAD_LEVEL_MASK, 1, 16'h0040, 0, 0, 0, 0);
      ck(got !== (k[1] ? CHK_INVALID : CHK_SPEC) || mask !== 4'h5, "bad address");
    end
    {flt, cl} = {2'h0, 2'h2};
    run(OP_LOAD_CONTEXT_BLOCK, 1, 16'h0060, 16'h8001, 0, 0, 0);
    ck(got !== CHK_NONE || lsw !== 16'h7000, "other level");
    ck({sw, tl, te, th} !== 5'h17, "switch and trace");
    ck(wbq[8] !== 18'h10000 || wbq[9] !== 18'h100a0, "block words");
    ck(wbq[7] !== 18'h10077 || wbq[1] !== 18'h20042, "last word, base");
    @(negedge clk) ret = 1;
    @(negedge clk) ret = 0;
    ck(th !== 1'b0, "hold not released");
    results;
  end
  initial begin
    #200us;
    miscompares++;
    results;
  end
endmodule : level_mask_scan_execution_bench
